/* peh_pkg.sv */
// constants, register map and field layout of the external handshake block
package peh_pkg;
   // register byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] CMD_ADDR    = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   // control fields
   localparam int STANDALONE_BIT  = 0;
   localparam int IFACE_LSB       = 1;
   localparam int HS_VT_BIT       = 3;
   localparam int HS_3V3_BIT      = 4;
   localparam int BUSY_SET_BIT    = 5;
   localparam int FAIL_SET_BIT    = 6;
   localparam int START_SET_BIT   = 7;
   localparam int PASS_SET_BIT    = 8;
   localparam int PASS_MODE_LSB   = 9;
   localparam int MD_USED_BIT     = 11;
   localparam int SUPPLY_SEL_LSB  = 12;
   localparam int SUPPLY_STEP_BIT = 14;
   localparam int TGT_RST_BIT     = 15;
   localparam int BOOT_LVL_BIT    = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // command fields
   localparam int CMD_OK_BIT    = 0;
   localparam int CMD_FAIL_BIT  = 1;
   localparam int CMD_CLRF_BIT  = 2;
   // status fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_PASS_BIT  = 2;
   localparam int ST_FAIL_BIT  = 3;
   localparam int ST_FAULT_BIT = 4;
   localparam int ST_LOST_BIT  = 5;
   localparam int ST_VT_BIT    = 6;
   localparam int ST_RST_BIT   = 7;
   // synchroniser lanes
   localparam int SY_START_VT  = 0;
   localparam int SY_START_3V3 = 1;
   localparam int SY_VT_PRES   = 2;
   localparam int SY_OVERCUR   = 3;
   localparam int SY_VT_OK     = 4;
   localparam int SY_PIN7      = 5;
   localparam int SY_PIN9      = 6;
   localparam int SY_RST       = 7;
   localparam int SY_WIDTH     = 8;
   // timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SUPPLY_RISE_NS = 2000000;
   localparam int BLINK_HALF_NS  = 50000000;
   localparam int CNT_W          = 24;
   typedef enum logic [1:0] {IFACE_SWD = 2'b00, IFACE_JTAG = 2'b01, IFACE_UART = 2'b10} peh_iface_t;
   typedef enum logic [1:0] {PASS_RESULT = 2'b00, PASS_LED = 2'b01, PASS_WRITE = 2'b10} peh_pass_t;
   typedef enum logic [1:0] {SUP_OFF = 2'b00, SUP_3V3 = 2'b01, SUP_5V = 2'b10} peh_sup_t;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_POWER = 2'b01, ST_RUN = 2'b10} peh_state_t;
endpackage

/* peh_sync.sv */
// two-flop synchroniser with falling-edge pulses
`timescale 1ns/100ps
`default_nettype none
module peh_sync #(
   parameter int W = 8
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q,
   output logic      [W-1:0] fall
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_r <= '1;
         s2_r <= '1;
         s3_r <= '1;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign q    = s2_r;
   assign fall = s3_r & ~s2_r;
endmodule
`default_nettype wire

/* peh_core.sv */
// external handshake, target supply and uart pin control of the programmer
// How it works
// - busy output high for whole write operation
// - fail output high when write ends failed
// - controller pulses active-low start; device begins a write
// - pass output high when write ends successfully
// - supply-referenced handshake set only with swd target interface
// - handshake works only in standalone mode
// - at most one handshake set enabled
// - uart interface disables supply-referenced handshake signals
// - pass output has three modes and an enable
// - supply-referenced outputs low while reference supply absent
// - uart transmit and receive pins swap with boot-mode use
// - boot-mode output steers target into programming boot
// - target reset only pulls low, open drain
// - at most one target supply output on
// - overcurrent cuts target supply at once
// - reference too low after supply on stops supply
// - supply may follow each write operation
// - fixed 3.3v set usable without supplying target
// - start only on falling edge
// - start edges ignored during a write
// - busy drops low at completion whatever the result
// - supply-referenced outputs stay low after loss for the operation
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module peh_core #(
   parameter int SETTLE_CYC = (peh_pkg::SUPPLY_RISE_NS + peh_pkg::CLK_PERIOD_NS - 1) / peh_pkg::CLK_PERIOD_NS,
   parameter int BLINK_CYC  = peh_pkg::BLINK_HALF_NS / peh_pkg::CLK_PERIOD_NS
) (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        start_request_n,
   input  wire logic        start_request_n_3v3,
   input  wire logic        vtref_present,
   input  wire logic        vtref_valid,
   input  wire logic        supply_overcurrent,
   output logic             busy_flag_out,
   output logic             pass_result_out,
   output logic             fail_result_out,
   output logic             busy_flag_out_3v3,
   output logic             pass_result_out_3v3,
   output logic             supply_out_3v3,
   output logic             supply_out_5v,
   input  wire logic        target_system_reset_in,
   output logic             target_system_reset_out,
   output logic             target_system_reset_oe,
   output logic             boot_mode_terminal,
   input  wire logic        uart_tx_data,
   output logic             uart_rx_data,
   input  wire logic        pin7_in,
   output logic             pin7_out,
   output logic             pin7_oe,
   input  wire logic        pin9_in,
   output logic             pin9_out,
   output logic             pin9_oe
);
   logic [31:0]               ctrl_r;
   peh_pkg::peh_state_t       state_r;
   logic [peh_pkg::CNT_W-1:0] settle_r;
   logic [peh_pkg::CNT_W-1:0] blink_cnt_r;
   logic                      blink_r;
   logic                      pass_r;
   logic                      fail_r;
   logic                      fault_r;
   logic                      vt_lost_r;
   logic                      supply_on_r;
   logic [peh_pkg::SY_WIDTH-1:0] sy_q;
   logic [peh_pkg::SY_WIDTH-1:0] sy_fall;
   logic                      vt_act;
   logic                      v3_act;
   logic                      vt_gate;
   logic                      start_go;
   logic                      fin_ok;
   logic                      fin_fail;
   logic                      busy_int;
   logic                      pass_lvl;
   logic                      supply_want;
   logic                      settle_done;
   logic                      clr_fault;
   logic                      md_used;
   peh_pkg::peh_iface_t       iface;
   peh_pkg::peh_pass_t        pass_mode;
   peh_pkg::peh_sup_t         sup_sel;

   function automatic logic fld(input logic [31:0] v, input int pos);
      fld = v[pos];
   endfunction

   // pin lanes pass two flops before any use
   peh_sync #(.W(peh_pkg::SY_WIDTH)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        ({target_system_reset_in, pin9_in, pin7_in, vtref_valid, supply_overcurrent,
                  vtref_present, start_request_n_3v3, start_request_n}),
      .q        (sy_q),
      .fall     (sy_fall)
   );

   assign iface     = peh_pkg::peh_iface_t'(ctrl_r[peh_pkg::IFACE_LSB +: 2]);
   assign pass_mode = peh_pkg::peh_pass_t'(ctrl_r[peh_pkg::PASS_MODE_LSB +: 2]);
   assign sup_sel   = peh_pkg::peh_sup_t'(ctrl_r[peh_pkg::SUPPLY_SEL_LSB +: 2]);
   assign md_used   = fld(ctrl_r, peh_pkg::MD_USED_BIT);

   // handshake set qualification
   assign vt_act = fld(ctrl_r, peh_pkg::HS_VT_BIT) && fld(ctrl_r, peh_pkg::STANDALONE_BIT)
                   && iface == peh_pkg::IFACE_SWD;
   assign v3_act = fld(ctrl_r, peh_pkg::HS_3V3_BIT) && fld(ctrl_r, peh_pkg::STANDALONE_BIT);
   assign vt_gate = sy_q[peh_pkg::SY_VT_PRES] && !vt_lost_r;

   // falling edges only, and only while idle
   assign start_go = state_r == peh_pkg::ST_IDLE && fld(ctrl_r, peh_pkg::START_SET_BIT)
                     && ((vt_act && sy_q[peh_pkg::SY_VT_PRES] && sy_fall[peh_pkg::SY_START_VT])
                     || (v3_act && sy_fall[peh_pkg::SY_START_3V3]));

   assign settle_done = settle_r >= peh_pkg::CNT_W'(SETTLE_CYC);
   assign clr_fault   = reg_wr && reg_addr == peh_pkg::CMD_ADDR && reg_wdata[peh_pkg::CMD_CLRF_BIT];
   assign fin_ok   = state_r == peh_pkg::ST_RUN && reg_wr && reg_addr == peh_pkg::CMD_ADDR
                     && reg_wdata[peh_pkg::CMD_OK_BIT] && !reg_wdata[peh_pkg::CMD_FAIL_BIT]
                     && !sy_q[peh_pkg::SY_OVERCUR];
   assign fin_fail = (state_r == peh_pkg::ST_RUN && ((reg_wr && reg_addr == peh_pkg::CMD_ADDR
                     && reg_wdata[peh_pkg::CMD_FAIL_BIT]) || sy_q[peh_pkg::SY_OVERCUR]))
                     || (state_r == peh_pkg::ST_POWER && (fault_r || sy_q[peh_pkg::SY_OVERCUR]
                     || (settle_done && !sy_q[peh_pkg::SY_VT_OK])));
   assign busy_int = state_r != peh_pkg::ST_IDLE;

   // control register; both handshake sets never stored together
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ctrl_r <= peh_pkg::CTRL_RESET;
      else if (reg_wr && reg_addr == peh_pkg::CTRL_ADDR)
      begin
         ctrl_r <= reg_wdata;
         ctrl_r[peh_pkg::HS_3V3_BIT] <= reg_wdata[peh_pkg::HS_3V3_BIT]
                                       && !reg_wdata[peh_pkg::HS_VT_BIT];
      end
   end

   // write operation sequence
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= peh_pkg::ST_IDLE;
      else
      begin
         case (state_r)
            peh_pkg::ST_IDLE:
               if (start_go)
                  state_r <= (sup_sel != peh_pkg::SUP_OFF) ? peh_pkg::ST_POWER : peh_pkg::ST_RUN;
            peh_pkg::ST_POWER:
               if (fin_fail)
                  state_r <= peh_pkg::ST_IDLE;
               else if (settle_done)
                  state_r <= peh_pkg::ST_RUN;
            peh_pkg::ST_RUN:
               if (fin_ok || fin_fail)
                  state_r <= peh_pkg::ST_IDLE;
            default:
               state_r <= peh_pkg::ST_IDLE;
         endcase
      end
   end

   // supply settle counter
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         settle_r <= '0;
      else if (!supply_on_r || state_r != peh_pkg::ST_POWER)
         settle_r <= '0;
      else if (!settle_done)
         settle_r <= settle_r + peh_pkg::CNT_W'(1);
   end

   // result flags, cleared at start
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pass_r <= 1'b0;
         fail_r <= 1'b0;
      end
      else if (start_go)
      begin
         pass_r <= 1'b0;
         fail_r <= 1'b0;
      end
      else if (fin_fail)
         fail_r <= 1'b1;
      else if (fin_ok)
         pass_r <= 1'b1;
   end

   // loss of reference held until next start
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         vt_lost_r <= 1'b0;
      else if (start_go)
         vt_lost_r <= 1'b0;
      else if (busy_int && !sy_q[peh_pkg::SY_VT_PRES])
         vt_lost_r <= 1'b1;
   end

   // supply fault: overcurrent or low reference after rise
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         fault_r <= 1'b0;
      else if (sy_q[peh_pkg::SY_OVERCUR] && supply_on_r)
         fault_r <= 1'b1;
      else if (state_r == peh_pkg::ST_POWER && settle_done && !sy_q[peh_pkg::SY_VT_OK])
         fault_r <= 1'b1;
      else if (clr_fault)
         fault_r <= 1'b0;
   end

   // supply either follows the write or stays on
   assign supply_want = sup_sel != peh_pkg::SUP_OFF && !fault_r && !sy_q[peh_pkg::SY_OVERCUR]
                        && (!fld(ctrl_r, peh_pkg::SUPPLY_STEP_BIT) || busy_int);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         supply_on_r    <= 1'b0;
         supply_out_3v3 <= 1'b0;
         supply_out_5v  <= 1'b0;
      end
      else
      begin
         supply_on_r    <= supply_want;
         supply_out_3v3 <= supply_want && sup_sel == peh_pkg::SUP_3V3;
         supply_out_5v  <= supply_want && sup_sel == peh_pkg::SUP_5V;
      end
   end

   // blink timebase for led mode
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end
      else if (!busy_int)
      begin
         blink_cnt_r <= '0;
         blink_r     <= 1'b0;
      end
      else if (blink_cnt_r >= peh_pkg::CNT_W'(BLINK_CYC - 1))
      begin
         blink_cnt_r <= '0;
         blink_r     <= !blink_r;
      end
      else
         blink_cnt_r <= blink_cnt_r + peh_pkg::CNT_W'(1);
   end

   always_comb
   begin
      case (pass_mode)
         peh_pkg::PASS_LED:   pass_lvl = busy_int ? blink_r : pass_r;
         peh_pkg::PASS_WRITE: pass_lvl = busy_int;
         default:             pass_lvl = pass_r;
      endcase
   end

   // handshake outputs
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_flag_out       <= 1'b0;
         pass_result_out     <= 1'b0;
         fail_result_out     <= 1'b0;
         busy_flag_out_3v3   <= 1'b0;
         pass_result_out_3v3 <= 1'b0;
      end
      else
      begin
         busy_flag_out       <= vt_act && vt_gate && fld(ctrl_r, peh_pkg::BUSY_SET_BIT) && busy_int;
         pass_result_out     <= vt_act && vt_gate && fld(ctrl_r, peh_pkg::PASS_SET_BIT) && pass_lvl;
         fail_result_out     <= vt_act && vt_gate && fld(ctrl_r, peh_pkg::FAIL_SET_BIT) && fail_r;
         busy_flag_out_3v3   <= v3_act && fld(ctrl_r, peh_pkg::BUSY_SET_BIT) && busy_int;
         pass_result_out_3v3 <= v3_act && fld(ctrl_r, peh_pkg::PASS_SET_BIT) && pass_lvl;
      end
   end

   // target reset, boot mode and uart pin steering
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         target_system_reset_out <= 1'b0;
         target_system_reset_oe  <= 1'b0;
         boot_mode_terminal      <= 1'b0;
         pin7_out                <= 1'b1;
         pin7_oe                 <= 1'b0;
         pin9_out                <= 1'b1;
         pin9_oe                 <= 1'b0;
         uart_rx_data            <= 1'b1;
      end
      else
      begin
         target_system_reset_out <= 1'b0;
         target_system_reset_oe  <= fld(ctrl_r, peh_pkg::TGT_RST_BIT);
         boot_mode_terminal      <= md_used && fld(ctrl_r, peh_pkg::BOOT_LVL_BIT);
         pin7_out                <= uart_tx_data;
         pin9_out                <= uart_tx_data;
         pin7_oe                 <= iface == peh_pkg::IFACE_UART && !md_used;
         pin9_oe                 <= iface == peh_pkg::IFACE_UART && md_used;
         uart_rx_data            <= md_used ? sy_q[peh_pkg::SY_PIN7] : sy_q[peh_pkg::SY_PIN9];
      end
   end

   // register read, data in the following cycle only
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= '0;
      else if (!reg_rd)
         reg_rdata <= '0;
      else if (reg_addr == peh_pkg::CTRL_ADDR)
         reg_rdata <= ctrl_r;
      else if (reg_addr == peh_pkg::STATUS_ADDR)
      begin
         reg_rdata <= '0;
         reg_rdata[peh_pkg::ST_STATE_LSB +: 2] <= state_r;
         reg_rdata[peh_pkg::ST_PASS_BIT]  <= pass_r;
         reg_rdata[peh_pkg::ST_FAIL_BIT]  <= fail_r;
         reg_rdata[peh_pkg::ST_FAULT_BIT] <= fault_r;
         reg_rdata[peh_pkg::ST_LOST_BIT]  <= vt_lost_r;
         reg_rdata[peh_pkg::ST_VT_BIT]    <= sy_q[peh_pkg::SY_VT_PRES];
         reg_rdata[peh_pkg::ST_RST_BIT]   <= sy_q[peh_pkg::SY_RST];
      end
      else
         reg_rdata <= '0;
   end

   sequence run_ok_s;
      state_r == peh_pkg::ST_RUN && fin_ok;
   endsequence

   sequence run_fail_s;
      state_r == peh_pkg::ST_RUN && fin_fail;
   endsequence

   busy_high_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (busy_int && vt_act && vt_gate && fld(ctrl_r, peh_pkg::BUSY_SET_BIT)) |=> busy_flag_out)
      else $error("busy not high during write");

   fail_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      run_fail_s |=> fail_r && state_r == peh_pkg::ST_IDLE)
      else $error("failed write not flagged");

   pass_out_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      run_ok_s |=> pass_r && !fail_r && !busy_int)
      else $error("good write not flagged");

   start_edge_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == peh_pkg::ST_IDLE && !start_go) |=> state_r == peh_pkg::ST_IDLE)
      else $error("write began without start edge");

   start_ignore_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_r == peh_pkg::ST_RUN && !fin_ok && !fin_fail) |=> state_r == peh_pkg::ST_RUN && $stable(pass_r))
      else $error("start edge disturbed a write");

   set_excl_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(ctrl_r[peh_pkg::HS_VT_BIT] && ctrl_r[peh_pkg::HS_3V3_BIT]))
      else $error("both handshake sets enabled");

   uart_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      iface == peh_pkg::IFACE_UART |=> !busy_flag_out && !pass_result_out && !fail_result_out)
      else $error("referenced handshake active over uart");

   vt_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (vt_lost_r && busy_int) |=> !busy_flag_out && !pass_result_out && !fail_result_out)
      else $error("referenced outputs high after supply loss");

   supply_one_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(supply_out_3v3 && supply_out_5v))
      else $error("both supplies on");

   overcur_cut_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      sy_q[peh_pkg::SY_OVERCUR] |=> !supply_out_3v3 && !supply_out_5v)
      else $error("supply kept on under overcurrent");

   reset_od_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      target_system_reset_oe |-> !target_system_reset_out)
      else $error("target reset driven high");
endmodule
`default_nettype wire

/* peh_partner.sv */
// production controller and target cpu model facing the handshake block
`timescale 1ns/100ps
`default_nettype none
module peh_partner (
   input  wire logic core_clk,
   input  wire logic rst_oe,
   input  wire logic p7_out,
   input  wire logic p7_oe,
   input  wire logic p9_out,
   input  wire logic p9_oe,
   output logic      start_n,
   output logic      start_n_3v3,
   output logic      ref_pres,
   output logic      ref_ok,
   output logic      over_cur,
   output logic      rst_line,
   output logic      p7_line,
   output logic      p9_line
);
   logic tgt_tx;
   initial
   begin
      {start_n, start_n_3v3, ref_pres, ref_ok} = 4'hf;
      {over_cur, tgt_tx} = 2'h0;
   end
   // reset line pulled up, only ever pulled low by the programmer
   assign rst_line = ~rst_oe;
   // target drives whichever pin the programmer releases
   assign p7_line = p7_oe ? p7_out : tgt_tx;
   assign p9_line = p9_oe ? p9_out : tgt_tx;
   // low pulse on one start line, reference lines left as driven before
   task automatic pulse(input logic hv);
      @(posedge core_clk);
      if (hv)
         start_n_3v3 <= 1'b0;
      else
         start_n <= 1'b0;
      repeat (4) @(posedge core_clk);
      start_n <= 1'b1;
      start_n_3v3 <= 1'b1;
   endtask
   // line levels {start, ref present, ref valid, overcurrent, target tx}
   task automatic drive(input logic [4:0] v);
      {start_n, ref_pres, ref_ok, over_cur, tgt_tx} <= v;
   endtask
endmodule
`default_nettype wire

/* programmer_external_handshake_bench.sv */
// self-checking bench of the external handshake block
`timescale 1ns/100ps
`default_nettype none
module programmer_external_handshake_bench;
   logic        core_clk, rst_n, reg_wr, reg_rd, uart_tx_data, hi, lo;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv, base, c3;
   logic [31:0] bad [3];
   logic        st_n, st3_n, rpres, rok, ocur, rline, rout, roe, boot;
   logic        busy, pass, fail, busy3, pass3, sup3, sup5, rx, p7o, p7e, p9o, p9e, p7l, p9l;
   int          failures, checks_done;
   wire logic [3:0] mon = {sup5, sup3, busy3, busy};
   peh_core #(.SETTLE_CYC(20), .BLINK_CYC(4)) dut_u (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_request_n(st_n),
      .start_request_n_3v3(st3_n), .vtref_present(rpres), .vtref_valid(rok), .supply_overcurrent(ocur),
      .busy_flag_out(busy), .pass_result_out(pass), .fail_result_out(fail), .busy_flag_out_3v3(busy3),
      .pass_result_out_3v3(pass3), .supply_out_3v3(sup3), .supply_out_5v(sup5),
      .target_system_reset_in(rline), .target_system_reset_out(rout), .target_system_reset_oe(roe),
      .boot_mode_terminal(boot), .uart_tx_data(uart_tx_data), .uart_rx_data(rx), .pin7_in(p7l),
      .pin7_out(p7o), .pin7_oe(p7e), .pin9_in(p9l), .pin9_out(p9o), .pin9_oe(p9e));
   peh_partner pm_u (
      .core_clk(core_clk), .rst_oe(roe), .p7_out(p7o), .p7_oe(p7e), .p9_out(p9o), .p9_oe(p9e),
      .start_n(st_n), .start_n_3v3(st3_n), .ref_pres(rpres), .ref_ok(rok), .over_cur(ocur),
      .rst_line(rline), .p7_line(p7l), .p9_line(p9l));
   function automatic logic [31:0] f(input int n);
      return 32'h1 << n;
   endfunction
   task automatic wrap_up();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   // bounded wait for one monitored output, then back onto the edge
   task automatic wait_for(input int idx, input logic v);
      for (int i = 0; i < 100; i++)
      begin
         @(posedge core_clk);
         #1;
         if (mon[idx] === v)
            break;
      end
      chk(mon[idx], v);
      if (mon[idx] !== v)
         wrap_up();
      else
         @(posedge core_clk);
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial
   begin
      {rst_n, reg_wr, reg_rd, uart_tx_data, reg_addr, reg_wdata} = '0;
      failures = 0;
      checks_done = 0;
      base = f(peh_pkg::STANDALONE_BIT) | f(peh_pkg::HS_VT_BIT) | f(peh_pkg::BUSY_SET_BIT)
           | f(peh_pkg::FAIL_SET_BIT) | f(peh_pkg::START_SET_BIT) | f(peh_pkg::PASS_SET_BIT);
      c3 = f(peh_pkg::STANDALONE_BIT) | f(peh_pkg::HS_3V3_BIT) | f(peh_pkg::BUSY_SET_BIT)
         | f(peh_pkg::START_SET_BIT) | f(peh_pkg::PASS_SET_BIT);
      bad = '{base | 32'h2, base | 32'h4, base & ~32'h1};
      step(16);
      rst_n <= 1'b1;
      step(2);
      chk({busy, pass, fail, busy3, pass3, sup3, sup5}, 0);
      rd(peh_pkg::CTRL_ADDR, rv);
      chk(rv, peh_pkg::CTRL_RESET);
      rd(8'h3c, rv);
      chk(rv, 0);
      $display("test reset done");
      // modes: result, blink, high while writing, output disabled
      for (int m = 0; m < 4; m++)
      begin
         wr(peh_pkg::CTRL_ADDR, (base | {30'h0, 2'(m % 3)} << peh_pkg::PASS_MODE_LSB)
            ^ (m == 3 ? f(peh_pkg::PASS_SET_BIT) : 32'h0));
         pm_u.pulse(1'b0);
         wait_for(0, 1'b1);
         {hi, lo} = 2'b01;
         for (int i = 0; i < 10; i++)
         begin
            @(posedge core_clk);
            #1 {hi, lo} = {hi | pass, lo & pass};
         end
         chk({hi, lo}, m == 2 ? 2'b11 : m == 1 ? 2'b10 : 2'b00);
         pm_u.pulse(1'b0);
         wr(peh_pkg::CMD_ADDR, f(m == 2 ? peh_pkg::CMD_FAIL_BIT : peh_pkg::CMD_OK_BIT));
         wait_for(0, 1'b0);
         chk({pass, fail}, m == 2 ? 2'b01 : m == 3 ? 2'b00 : 2'b10);
         step(8);
         chk(busy, 1'b0);
      end
      wr(peh_pkg::CTRL_ADDR, base & ~f(peh_pkg::START_SET_BIT));
      pm_u.drive(5'b01100);
      step(6);
      wr(peh_pkg::CTRL_ADDR, base);
      pm_u.drive(5'b11100);
      step(8);
      chk(busy, 1'b0);
      $display("test results done");
      wr(peh_pkg::CTRL_ADDR, base | f(peh_pkg::PASS_MODE_LSB + 1));
      pm_u.pulse(1'b0);
      wait_for(0, 1'b1);
      pm_u.drive(5'b10100);
      step(6);
      chk({busy, pass, fail}, 0);
      pm_u.drive(5'b11100);
      step(6);
      chk({busy, pass, fail}, 0);
      wr(peh_pkg::CMD_ADDR, f(peh_pkg::CMD_OK_BIT));
      foreach (bad[i])
      begin
         wr(peh_pkg::CTRL_ADDR, bad[i]);
         pm_u.pulse(1'b0);
         step(10);
         chk(busy, 1'b0);
      end
      wr(peh_pkg::CTRL_ADDR, base | f(peh_pkg::HS_3V3_BIT));
      rd(peh_pkg::CTRL_ADDR, rv);
      chk(rv[peh_pkg::HS_3V3_BIT], 1'b0);
      $display("test gating done");
      wr(peh_pkg::CTRL_ADDR, c3);
      pm_u.pulse(1'b1);
      wait_for(1, 1'b1);
      wr(peh_pkg::CMD_ADDR, f(peh_pkg::CMD_OK_BIT));
      wait_for(1, 1'b0);
      chk({pass3, busy}, 2'b10);
      wr(peh_pkg::CTRL_ADDR, c3 | f(peh_pkg::SUPPLY_STEP_BIT) | f(peh_pkg::SUPPLY_SEL_LSB));
      step(4);
      chk(sup3, 1'b0);
      pm_u.pulse(1'b1);
      wait_for(2, 1'b1);
      wait_for(1, 1'b1);
      step(30);
      wr(peh_pkg::CMD_ADDR, f(peh_pkg::CMD_OK_BIT));
      wait_for(2, 1'b0);
      chk(sup5, 1'b0);
      wr(peh_pkg::CTRL_ADDR, f(peh_pkg::SUPPLY_SEL_LSB + 1));
      wait_for(3, 1'b1);
      chk(sup3, 1'b0);
      pm_u.drive(5'b11110);
      step(5);
      chk(sup5, 1'b0);
      rd(peh_pkg::STATUS_ADDR, rv);
      chk(rv[peh_pkg::ST_FAULT_BIT], 1'b1);
      pm_u.drive(5'b11000);
      wr(peh_pkg::CMD_ADDR, f(peh_pkg::CMD_CLRF_BIT));
      wr(peh_pkg::CTRL_ADDR, base | f(peh_pkg::SUPPLY_SEL_LSB + 1));
      pm_u.pulse(1'b0);
      wait_for(0, 1'b1);
      wait_for(3, 1'b0);
      wait_for(0, 1'b0);
      chk(fail, 1'b1);
      $display("test supply done");
      wr(peh_pkg::CTRL_ADDR, 32'h4 | f(peh_pkg::MD_USED_BIT) | f(peh_pkg::BOOT_LVL_BIT) | f(peh_pkg::TGT_RST_BIT));
      step(4);
      chk({p7e, p9e, boot, roe, rout}, 5'b01110);
      rd(peh_pkg::STATUS_ADDR, rv);
      chk(rv[peh_pkg::ST_RST_BIT], 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         pm_u.drive({4'b1100, ~i[0]});
         uart_tx_data <= i[0];
         step(6);
         chk({rx, p9o}, {~i[0], i[0]});
      end
      wr(peh_pkg::CTRL_ADDR, 32'h4);
      step(4);
      chk({p7e, p9e, boot, roe}, 4'b1000);
      for (int i = 0; i < 2; i++)
      begin
         pm_u.drive({4'b1100, ~i[0]});
         uart_tx_data <= i[0];
         step(6);
         chk({rx, p7o}, {~i[0], i[0]});
      end
      $display("test pins done");
      wrap_up();
   end
endmodule
`default_nettype wire
